// >>> rtl/tm8_pkg.sv
// shared constants, register map and carrier types for the 8-bit waveform timer
package tm8_pkg;

  // register byte offsets on the AXI4-Lite slave
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_COUNT = 5'h04;
  localparam logic [4:0] OFS_COMPARE = 5'h08;
  localparam logic [4:0] OFS_FLAGS = 5'h0c;
  localparam logic [4:0] OFS_STATUS = 5'h10;

  // field positions
  localparam int FLAG_OVF_POS = 0;
  localparam int FLAG_CMP_POS = 1;
  localparam int STAT_OCB_POS = 0;
  localparam int STAT_DOWN_POS = 1;
  localparam int STAT_ACT_LSB = 8;

  // values after reset and fixed counter levels
  localparam logic [8:0] CTRL_RESET = 9'h000;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;

  // clock select: zero stops, one runs on every system clock, others use the prescaler tick
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIRECT = 3'h1;

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    WM_NORMAL = 2'h0,
    WM_PHASE = 2'h1,
    WM_CTC = 2'h2,
    WM_FAST = 2'h3
  } tm8_wave_t;

  typedef enum logic [1:0] {
    COM_NONE = 2'h0,
    COM_TOGGLE = 2'h1,
    COM_CLEAR = 2'h2,
    COM_SET = 2'h3
  } tm8_com_t;

  // control register layout, bit 8 down to bit 0
  typedef struct packed {
    logic direction;
    logic force_compare_strobe;
    logic [2:0] clock_select;
    tm8_com_t compare_output_mode;
    tm8_wave_t waveform_mode;
  } tm8_ctrl_t;

endpackage : tm8_pkg

// >>> rtl/tm8_timer.sv
// 8-bit timer/counter with four waveform modes behind an AXI4-Lite register slave
// Operation
// - compare output mode zero leaves the output bit unchanged on any match
// - new output mode acts at next match; force strobe acts at once outside PWM
// - only the waveform mode shapes counting; output mode shapes only the output
// - normal mode increments always, wraps 0xff to 0x00, count writable anytime
// - normal mode sets overflow flag as counter becomes zero; counting never clears it
// - clear-on-compare mode counts up to compare value then clears to zero
// - clear-on-compare compare writes are direct; a missed match runs through 0xff
// - clear-on-compare with output mode 1 toggles output on every match
// - clear-on-compare sets overflow flag passing from max to 0x00
// - fast PWM counts bottom to max, cleared on the next timer clock
// - fast PWM mode 2 clears on match, sets at bottom; mode 3 inverse
// - fast PWM sets overflow flag each time counter reaches max
// - fast PWM compare at bottom gives spike; at max a constant level
// - fast PWM output mode 1 toggles on match with compare buffering kept
// - phase correct counts up, holds max one timer clock, counts down
// - phase correct mode 2 clears on up match, sets on down match; 3 inverts
// - phase correct sets overflow flag each time counter reaches bottom
// - phase correct mode 2 compare at bottom gives constant low, at max constant high
// - phase correct output at max equals up-match result, even without a match
// - phase correct resolution fixed at 8 bits, turning at fixed max
// - compare match sets compare flag; write-one or interrupt service clears it
// - PWM compare writes go through a buffer loaded at top or bottom
// - a counter write blocks compare matches for the next timer clock
// - clock select zero stops the counter; software still reads and writes it
module tm8_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic prescale_tick,
  input wire logic overflow_service,
  input wire logic compare_service,
  output logic overflow_flag,
  output logic compare_flag,
  output logic compare_output_pin,
  output logic compare_output_pin_oe
);

  tm8_pkg::tm8_ctrl_t ctrl;
  logic [7:0] counter_value;
  logic [7:0] compare_value;
  logic [7:0] compare_buffer;
  logic count_down;
  logic match_block;
  logic compare_output_bit;
  logic [4:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;

  // write channel: address and data are caught independently, the write fires once both are held
  wire wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire [31:0] wr_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire wr_ctrl = wr_fire && (aw_addr == tm8_pkg::OFS_CTRL);
  wire wr_count = wr_fire && (aw_addr == tm8_pkg::OFS_COUNT) && w_strb[0];
  wire wr_compare = wr_fire && (aw_addr == tm8_pkg::OFS_COMPARE) && w_strb[0];
  wire wr_flags = wr_fire && (aw_addr == tm8_pkg::OFS_FLAGS) && w_strb[0];
  wire wr_mapped = (aw_addr == tm8_pkg::OFS_CTRL) || (aw_addr == tm8_pkg::OFS_COUNT) ||
                   (aw_addr == tm8_pkg::OFS_COMPARE) || (aw_addr == tm8_pkg::OFS_FLAGS) ||
                   (aw_addr == tm8_pkg::OFS_STATUS);
  wire [31:0] ctrl_merged = ({23'h0, ctrl} & ~wr_mask) | (w_data & wr_mask);
  wire tm8_pkg::tm8_ctrl_t next_ctrl = ctrl_merged[8:0];
  wire force_now = wr_ctrl && next_ctrl.force_compare_strobe;
  // the strobe is judged by the settings written with it, not by the ones it replaces
  wire force_act = force_now && (next_ctrl.compare_output_mode != tm8_pkg::COM_NONE) &&
                   (next_ctrl.waveform_mode == tm8_pkg::WM_NORMAL ||
                    next_ctrl.waveform_mode == tm8_pkg::WM_CTC);

  // mode decode; the output mode never reaches the counter path
  wire tm8_pkg::tm8_wave_t wm = ctrl.waveform_mode;
  wire tm8_pkg::tm8_com_t com = ctrl.compare_output_mode;
  wire is_pwm = (wm == tm8_pkg::WM_PHASE) || (wm == tm8_pkg::WM_FAST);
  wire com_on = (com != tm8_pkg::COM_NONE);

  // timer clock enable: stopped on select zero, else every clock or the prescaler tick
  wire timer_clock_enable = (ctrl.clock_select == tm8_pkg::CS_STOP) ? 1'b0 :
                            (ctrl.clock_select == tm8_pkg::CS_DIRECT) ? 1'b1 : prescale_tick;

  wire at_max = (counter_value == tm8_pkg::CNT_MAX);
  wire at_bottom = (counter_value == tm8_pkg::CNT_BOTTOM);
  // a counter write masks the comparator for one timer clock
  wire match = (counter_value == compare_value) && !match_block;
  wire tick_match = timer_clock_enable && match;

  // counting sequence per waveform mode; a software write has priority
  logic [7:0] next_count;
  logic next_down;
  always_comb begin
    next_count = counter_value;
    next_down = count_down;
    if (wr_count) begin
      next_count = w_data[7:0];
    end else if (timer_clock_enable) begin
      case (wm)
        tm8_pkg::WM_NORMAL: begin
          next_count = counter_value + 8'h01; // wraps 0xff to 0x00
          next_down = 1'b0;
        end
        tm8_pkg::WM_CTC: begin
          // a missed match simply lets the count roll through 0xff
          next_count = match ? tm8_pkg::CNT_BOTTOM : counter_value + 8'h01;
          next_down = 1'b0;
        end
        tm8_pkg::WM_FAST: begin
          next_count = at_max ? tm8_pkg::CNT_BOTTOM : counter_value + 8'h01;
          next_down = 1'b0;
        end
        tm8_pkg::WM_PHASE: begin
          // turns at the fixed max, so max lasts exactly one timer clock
          if (!count_down && at_max) begin
            next_count = counter_value - 8'h01;
            next_down = 1'b1;
          end else if (count_down && at_bottom) begin
            next_count = counter_value + 8'h01;
            next_down = 1'b0;
          end else begin
            next_count = count_down ? counter_value - 8'h01 : counter_value + 8'h01;
          end
        end
        default: begin
          next_count = counter_value;
        end
      endcase
    end
  end

  // overflow event per mode
  wire ovf_event = timer_clock_enable && !wr_count && (
                   ((wm == tm8_pkg::WM_NORMAL || wm == tm8_pkg::WM_CTC) && at_max &&
                    next_count == tm8_pkg::CNT_BOTTOM) ||
                   (wm == tm8_pkg::WM_FAST && at_max) ||
                   (wm == tm8_pkg::WM_PHASE && at_bottom && count_down));

  // buffer reload point: bottom for fast pwm, top for phase correct
  wire reload = timer_clock_enable && at_max && is_pwm;

  // output action of a compare match, or of the force strobe outside pwm
  logic next_ocb;
  always_comb begin
    next_ocb = compare_output_bit;
    if (force_act) begin
      // force uses the freshly written output mode and sets no flag
      case (next_ctrl.compare_output_mode)
        tm8_pkg::COM_TOGGLE: next_ocb = !compare_output_bit;
        tm8_pkg::COM_CLEAR: next_ocb = 1'b0;
        tm8_pkg::COM_SET: next_ocb = 1'b1;
        default: next_ocb = compare_output_bit;
      endcase
    end else if (timer_clock_enable && com_on) begin
      case (wm)
        tm8_pkg::WM_FAST: begin
          // bottom wins over a same-cycle match, giving the constant level at max
          if (com == tm8_pkg::COM_TOGGLE) begin
            if (match) next_ocb = !compare_output_bit;
          end else if (at_max) begin
            next_ocb = (com == tm8_pkg::COM_CLEAR);
          end else if (match) begin
            next_ocb = (com == tm8_pkg::COM_SET);
          end
        end
        tm8_pkg::WM_PHASE: begin
          if (com == tm8_pkg::COM_TOGGLE) begin
            next_ocb = compare_output_bit; // no toggle action in phase correct
          end else if (compare_value == tm8_pkg::CNT_MAX) begin
            next_ocb = (com == tm8_pkg::COM_CLEAR); // constant high non-inverted
          end else if (compare_value == tm8_pkg::CNT_BOTTOM) begin
            next_ocb = (com == tm8_pkg::COM_SET); // constant low non-inverted
          end else if (at_max && !count_down) begin
            next_ocb = (com == tm8_pkg::COM_SET); // up-match level at max
          end else if (match) begin
            next_ocb = count_down ? (com == tm8_pkg::COM_CLEAR) : (com == tm8_pkg::COM_SET);
          end
        end
        default: begin
          // normal and ctc: toggle, clear or set on match
          if (match) begin
            case (com)
              tm8_pkg::COM_TOGGLE: next_ocb = !compare_output_bit;
              tm8_pkg::COM_CLEAR: next_ocb = 1'b0;
              tm8_pkg::COM_SET: next_ocb = 1'b1;
              default: next_ocb = compare_output_bit;
            endcase
          end
        end
      endcase
    end
  end

  // control register; the force bit is a strobe and never stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= tm8_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= {next_ctrl.direction, 1'b0, next_ctrl[6:0]};
    end
  end

  // counter, direction and match blocking
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_value <= tm8_pkg::COUNT_RESET;
      count_down <= 1'b0;
      match_block <= 1'b0;
    end else begin
      counter_value <= next_count;
      count_down <= next_down;
      match_block <= wr_count || (match_block && !timer_clock_enable);
    end
  end

  // compare value: direct outside pwm, through the buffer in pwm modes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_value <= tm8_pkg::COMPARE_RESET;
      compare_buffer <= tm8_pkg::COMPARE_RESET;
    end else begin
      if (wr_compare) compare_buffer <= w_data[7:0];
      if (wr_compare && !is_pwm) begin
        compare_value <= w_data[7:0];
      end else if (reload) begin
        compare_value <= compare_buffer;
      end
    end
  end

  // sticky flags: an event in the clearing cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_flag <= 1'b0;
      compare_flag <= 1'b0;
    end else begin
      overflow_flag <= ovf_event ||
        (overflow_flag && !overflow_service && !(wr_flags && w_data[tm8_pkg::FLAG_OVF_POS]));
      compare_flag <= tick_match ||
        (compare_flag && !compare_service && !(wr_flags && w_data[tm8_pkg::FLAG_CMP_POS]));
    end
  end

  // output bit and pin; the pin follows the bit only while an output mode is selected
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_output_bit <= 1'b0;
      compare_output_pin <= 1'b0;
      compare_output_pin_oe <= 1'b0;
    end else begin
      compare_output_bit <= next_ocb;
      compare_output_pin <= next_ocb && com_on;
      compare_output_pin_oe <= ctrl.direction;
    end
  end

  // axi write address and data holding registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 5'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // ready is offered only while the holding slot is empty; costs one cycle per beat
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tm8_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? tm8_pkg::RESP_OKAY : tm8_pkg::RESP_DECERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read mux; the compare register reads back what software last wrote
  wire [31:0] status_word = {16'h0, compare_value, 6'h00, count_down, compare_output_bit};
  wire [31:0] rd_word =
    (s_axi_araddr == tm8_pkg::OFS_CTRL) ? {23'h0, ctrl} :
    (s_axi_araddr == tm8_pkg::OFS_COUNT) ? {24'h0, counter_value} :
    (s_axi_araddr == tm8_pkg::OFS_COMPARE) ? {24'h0, compare_buffer} :
    (s_axi_araddr == tm8_pkg::OFS_FLAGS) ? {30'h0, compare_flag, overflow_flag} :
    (s_axi_araddr == tm8_pkg::OFS_STATUS) ? status_word : 32'h0;
  wire rd_mapped = (s_axi_araddr == tm8_pkg::OFS_CTRL) || (s_axi_araddr == tm8_pkg::OFS_COUNT) ||
                   (s_axi_araddr == tm8_pkg::OFS_COMPARE) || (s_axi_araddr == tm8_pkg::OFS_FLAGS) ||
                   (s_axi_araddr == tm8_pkg::OFS_STATUS);

  // read channel: one read at a time, answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= tm8_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_mapped ? tm8_pkg::RESP_OKAY : tm8_pkg::RESP_DECERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_top_up;
    timer_clock_enable && wm == tm8_pkg::WM_PHASE && !count_down && at_max && !wr_count;
  endsequence
  sequence s_down_from_max;
    count_down && counter_value == 8'hfe;
  endsequence

  a_com_zero_hold: assert property (
    (com == tm8_pkg::COM_NONE && !wr_ctrl) |=> $stable(compare_output_bit))
    else $error("output bit moved with output mode zero");
  a_force_toggle: assert property (
    (force_act && next_ctrl.compare_output_mode == tm8_pkg::COM_TOGGLE)
    |=> compare_output_bit != $past(compare_output_bit))
    else $error("force strobe did not toggle output");
  a_normal_wrap: assert property (
    (timer_clock_enable && wm == tm8_pkg::WM_NORMAL && at_max && !wr_count)
    |=> counter_value == 8'h00 && overflow_flag)
    else $error("normal mode wrap or overflow flag wrong");
  a_ctc_clear: assert property (
    (tick_match && wm == tm8_pkg::WM_CTC && !wr_count) |=> counter_value == 8'h00)
    else $error("ctc did not clear on match");
  a_ctc_toggle: assert property (
    (tick_match && wm == tm8_pkg::WM_CTC && com == tm8_pkg::COM_TOGGLE && !wr_ctrl)
    |=> compare_output_bit != $past(compare_output_bit))
    else $error("ctc toggle missing");
  a_fast_bottom: assert property (
    (timer_clock_enable && wm == tm8_pkg::WM_FAST && at_max && !wr_count)
    |=> counter_value == 8'h00 && overflow_flag)
    else $error("fast pwm did not restart at bottom");
  a_phase_turn: assert property (
    s_top_up |=> s_down_from_max)
    else $error("phase correct did not turn at max");
  a_cmp_flag_set: assert property (
    tick_match |=> compare_flag)
    else $error("compare flag not set after match");
  a_write_blocks: assert property (
    (match_block && !compare_flag) |=> !compare_flag)
    else $error("counter write did not block compare");
  a_stop_hold: assert property (
    (ctrl.clock_select == tm8_pkg::CS_STOP && !wr_count && !wr_ctrl)
    |=> counter_value == $past(counter_value))
    else $error("stopped counter moved");

endmodule : tm8_timer

// >>> test/test_tm8_timer.sv
// self-checking bench for the 8-bit waveform timer over its register slave
module test_tm8_timer;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic prescale_tick, overflow_service, compare_service;
  logic overflow_flag, compare_flag, compare_output_pin, compare_output_pin_oe;
  int errors, n_tests, cycles;
  logic [31:0] rd, rd2;
  logic [1:0] rsp;

  tm8_timer u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .prescale_tick(prescale_tick), .overflow_service(overflow_service),
    .compare_service(compare_service), .overflow_flag(overflow_flag),
    .compare_flag(compare_flag), .compare_output_pin(compare_output_pin),
    .compare_output_pin_oe(compare_output_pin_oe));

  // 250 MHz system clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // watchdog: the whole sequence needs well under this many cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("errors=%0d comparisons=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check_val

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    check_val({30'h0, got}, {30'h0, exp});
  endtask : check_resp

  // address and data offered together, each released when taken
  task automatic axi_write(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw, w;
    aw = 1;
    w = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask : axi_write

  task automatic axi_read(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : axi_read

  // reset values and unmapped places in both directions
  task automatic t_reset_map();
    axi_read(tm8_pkg::OFS_CTRL, rd, rsp);
    check_val(rd, 32'h0000_0000);
    axi_read(tm8_pkg::OFS_COUNT, rd, rsp);
    check_val(rd, {24'h0, tm8_pkg::COUNT_RESET});
    axi_read(5'h14, rd, rsp);
    check_resp(rsp, tm8_pkg::RESP_DECERR);
    check_val(rd, 32'h0000_0000);
    axi_write(5'h18, 32'h0000_00ff, rsp);
    check_resp(rsp, tm8_pkg::RESP_DECERR);
  endtask : t_reset_map

  // normal mode wraps and flags overflow; stopped counter stays writable
  task automatic t_normal();
    int n;
    axi_write(tm8_pkg::OFS_COUNT, 32'h0000_00f0, rsp);
    axi_write(tm8_pkg::OFS_CTRL, 32'h0000_0010, rsp);
    n = 0;
    while (overflow_flag !== 1'b1 && n < 40) begin
      @(posedge aclk);
      n = n + 1;
    end
    check_val({31'h0, overflow_flag}, 32'h1);
    axi_write(tm8_pkg::OFS_CTRL, 32'h0000_0000, rsp);
    axi_read(tm8_pkg::OFS_COUNT, rd, rsp);
    axi_read(tm8_pkg::OFS_COUNT, rd2, rsp);
    check_val(rd2, rd);
    check_val({31'h0, rd[7:5] == 3'h0}, 32'h1);
    axi_write(tm8_pkg::OFS_COUNT, 32'h0000_005a, rsp);
    axi_read(tm8_pkg::OFS_COUNT, rd, rsp);
    check_val(rd, 32'h0000_005a);
    overflow_service <= 1'b1;
    @(posedge aclk);
    overflow_service <= 1'b0;
    repeat (2) @(posedge aclk);
    check_val({31'h0, overflow_flag}, 32'h0);
  endtask : t_normal

  // clear-on-compare toggle: one pin change every compare+1 timer clocks
  task automatic t_ctc_toggle();
    int n;
    logic prev;
    axi_write(tm8_pkg::OFS_COUNT, 32'h0000_0000, rsp);
    axi_write(tm8_pkg::OFS_COMPARE, 32'h0000_0003, rsp);
    axi_write(tm8_pkg::OFS_CTRL, 32'h0000_0116, rsp);
    repeat (12) @(posedge aclk);
    check_val({31'h0, compare_output_pin_oe}, 32'h1);
    prev = compare_output_pin;
    while (compare_output_pin === prev) @(posedge aclk);
    prev = compare_output_pin;
    n = 0;
    while (compare_output_pin === prev && n < 20) begin
      @(posedge aclk);
      n = n + 1;
    end
    check_val(n, 32'd4);
    axi_write(tm8_pkg::OFS_CTRL, 32'h0000_0106, rsp);
    check_val({31'h0, compare_flag}, 32'h1);
    axi_write(tm8_pkg::OFS_FLAGS, 32'h0000_0002, rsp);
    @(posedge aclk);
    check_val({31'h0, compare_flag}, 32'h0);
  endtask : t_ctc_toggle

  // force strobe acts at once and sets no flag; the prescaler tick paces the count
  task automatic t_force_tick();
    axi_read(tm8_pkg::OFS_STATUS, rd, rsp);
    axi_write(tm8_pkg::OFS_CTRL, 32'h0000_0186, rsp);
    axi_read(tm8_pkg::OFS_STATUS, rd2, rsp);
    check_val({31'h0, rd2[tm8_pkg::STAT_OCB_POS]}, {31'h0, ~rd[tm8_pkg::STAT_OCB_POS]});
    check_val({31'h0, compare_flag}, 32'h0);
    axi_write(tm8_pkg::OFS_COUNT, 32'h0000_0000, rsp);
    axi_write(tm8_pkg::OFS_CTRL, 32'h0000_0020, rsp);
    repeat (5) begin
      prescale_tick <= 1'b1;
      @(posedge aclk);
      prescale_tick <= 1'b0;
      @(posedge aclk);
    end
    axi_read(tm8_pkg::OFS_COUNT, rd, rsp);
    check_val(rd, 32'h0000_0005);
    check_val({31'h0, compare_flag}, 32'h1);
    compare_service <= 1'b1;
    @(posedge aclk);
    compare_service <= 1'b0;
    repeat (2) @(posedge aclk);
    check_val({31'h0, compare_flag}, 32'h0);
  endtask : t_force_tick

  // pwm extreme compare values hold the pin at one level for a full period
  task automatic t_pwm_level(input logic [31:0] ctrl, input logic [7:0] cmp, input logic lvl);
    int bad;
    axi_write(tm8_pkg::OFS_COUNT, 32'h0000_0000, rsp);
    axi_write(tm8_pkg::OFS_COMPARE, {24'h0, cmp}, rsp);
    axi_write(tm8_pkg::OFS_CTRL, ctrl, rsp);
    repeat (1100) @(posedge aclk);
    bad = 0;
    repeat (520) begin
      @(posedge aclk);
      if (compare_output_pin !== lvl) bad = bad + 1;
    end
    check_val(bad, 32'd0);
    axi_write(tm8_pkg::OFS_CTRL, 32'h0000_0100, rsp);
  endtask : t_pwm_level

  initial begin
    errors = 0;
    n_tests = 0;
    cycles = 0;
    aresetn = 1'b0;
    s_axi_awaddr = 5'h00;
    s_axi_araddr = 5'h00;
    s_axi_awprot = 3'h0;
    s_axi_arprot = 3'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    prescale_tick = 1'b0;
    overflow_service = 1'b0;
    compare_service = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset_map();
    t_normal();
    t_ctc_toggle();
    t_force_tick();
    t_pwm_level(32'h0000_011b, 8'hff, 1'b1);
    t_pwm_level(32'h0000_0119, 8'h00, 1'b0);
    t_pwm_level(32'h0000_0119, 8'hff, 1'b1);
    finish_test();
  end
endmodule : test_tm8_timer
